// file: design/rar_cfg.svh
// timing and reset constants for the alarm and relay block
`ifndef RAR_CFG_SVH
`define RAR_CFG_SVH
`define RAR_CLK_HZ        40000000
`define RAR_TICK_MS       100
`define RAR_TICK_CYC      ((`RAR_CLK_HZ / 1000) * `RAR_TICK_MS)
`define RAR_SEC_TICKS     10
`define RAR_NUM_SLOTS     16
`define RAR_NUM_IN        8
`define RAR_NUM_OUT       8
`define RAR_ADDR_RST      16'h0000
`define RAR_DEB_RST       16'h0000
`define RAR_ONT_RST       8'h00
// register offsets
`define RAR_A_CTRL        8'h00
`define RAR_A_STAT        8'h04
`define RAR_A_MASK        8'h08
`define RAR_A_INLVL       8'h0c
`define RAR_A_INCUR       8'h10
`define RAR_A_INEN        8'h14
`define RAR_A_INMODE      8'h18
`define RAR_A_INDEB       8'h1c
`define RAR_A_OUTMOM      8'h20
`define RAR_A_OUTONT      8'h24
`define RAR_A_OUTCMD      8'h28
`define RAR_A_OUTST       8'h2c
`define RAR_A_SLOTSEL     8'h30
`define RAR_A_SLOTMATCH   8'h34
`define RAR_A_SLOTREPL    8'h38
`define RAR_A_ALARM       8'h3c
// field positions
`define RAR_CTRL_EXC      0
`define RAR_CTRL_NEXT     1
`define RAR_ST_ALARM      0
`define RAR_ST_FWD        1
`define RAR_ST_OUTIDLE    2
`define RAR_OUTCMD_ON     8
`define RAR_OUTCMD_GRP    9
`endif

// file: design/rar_pkg.sv
// types of the alarm and relay block
package rar_pkg;
  typedef enum logic [1:0] {RAR_MODE_STATUS, RAR_MODE_NO, RAR_MODE_NC}
    rar_mode_t;
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
  } rar_addr_t;
  typedef struct packed {
    logic        valid;
    logic [2:0]  input_num;
    logic        level;
  } rar_alarm_t;
endpackage

// file: design/rar_din.sv
// one digital input alarm detector with debounce
`include "rar_cfg.svh"
module rar_din
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // timing
  input  wire logic             tick,
  // configuration
  input  wire rar_pkg::rar_mode_t mode,
  input  wire logic [15:0]      deb_ticks,
  // synchronised input level
  input  wire logic             level,
  // alarm event, one cycle
  output logic                  fire
);
  logic        stable_r;
  logic        pend_r;
  logic        pend_lvl_r;
  logic [15:0] cnt_r;
  wire         chg      = level != stable_r;
  wire         want_fall = mode == rar_pkg::RAR_MODE_NO && !level; // [RQ6]
  wire         want_rise = mode == rar_pkg::RAR_MODE_NC && level;  // [RQ7]
  wire         want_any  = mode == rar_pkg::RAR_MODE_STATUS;       // [RQ8]
  wire         cond      = chg && (want_fall || want_rise || want_any);
  wire         cond_hold = pend_r && level == pend_lvl_r;
  wire         expired   = cond_hold && (tick ? cnt_r >= deb_ticks
                                              : deb_ticks == 16'h0000);
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stable_r   <= 1'b1;
      pend_r     <= 1'b0;
      pend_lvl_r <= 1'b0;
      cnt_r      <= 16'h0000;
      fire       <= 1'b0;
    end
    else
    begin
      fire <= 1'b0;
      if (expired)
      begin
        // must stay longer than the debounce time [RQ9]
        fire     <= 1'b1;
        stable_r <= level;
        pend_r   <= 1'b0;
      end
      else if (pend_r && !cond_hold)
      begin
        // left alarm condition early, timer restarts next time [RQ15]
        pend_r   <= 1'b0;
        stable_r <= level;
        cnt_r    <= 16'h0000;
      end
      else if (!pend_r && chg)
      begin
        if (cond)
        begin
          pend_r     <= 1'b1;
          pend_lvl_r <= level;
          cnt_r      <= 16'h0000;
        end
        else
          stable_r <= level;
      end
      else if (pend_r && tick && cnt_r != 16'hffff)
        cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule // rar_din

// file: design/rar_dout.sv
// one digital output, latched or momentary
`include "rar_cfg.svh"
module rar_dout
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // timing
  input  wire logic       sec_tick,
  // configuration
  input  wire logic       momentary,
  input  wire logic [7:0] on_secs,
  // commands, one cycle
  input  wire logic       cmd_on,
  input  wire logic       cmd_off,
  input  wire logic       cmd_grp,
  // output state and idle return report
  output logic            drive,
  output logic            idle_rpt
);
  logic [7:0] left_r;
  logic       grp_r;
  wire        run_out = drive && momentary && (left_r == 8'h00 ||
                        (sec_tick && left_r == 8'h01));
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      drive    <= 1'b0;
      left_r   <= 8'h00;
      grp_r    <= 1'b0;
      idle_rpt <= 1'b0;
    end
    else
    begin
      idle_rpt <= 1'b0;
      if (cmd_on)
      begin
        drive  <= 1'b1;
        left_r <= on_secs;
        grp_r  <= cmd_grp;
      end
      else if (cmd_off)
        drive <= 1'b0; // latched stays on until commanded off [RQ12]
      else if (run_out)
      begin
        drive    <= 1'b0; // momentary on-time expired [RQ13]
        idle_rpt <= grp_r; // report idle after group command [RQ14]
      end
      else if (drive && momentary && sec_tick)
        left_r <= left_r - 8'h01;
    end
  end
endmodule // rar_dout

// file: design/rar_top.sv
// alarm and relay logic of a telemetry remote unit
// Function
// RQ1: with exception reporting off no unsolicited alarm leaves the unit.
// RQ2: sixteen forwarding slots hold source, destination and replacements.
// RQ3: a frame matching a slot is resent with the replacement addresses.
// RQ4: an enabled input meeting its condition sends an alarm unpolled; of inputs firing in one cycle the code sends only the lowest-numbered.
// RQ5: a disabled input shows its level but never sends an alarm.
// RQ6: normally-open mode alarms on a high to low change.
// RQ7: normally-closed mode alarms on a low to high change.
// RQ8: status mode alarms on every change and reports the new level.
// RQ9: an alarm fires only after the condition outlasts the debounce time.
// RQ10: after reset each input is enabled, status mode, zero debounce.
// RQ11: advancing past the last input wraps the selection to the first.
// RQ12: a latched output stays on until commanded off.
// RQ13: a momentary output turns off when its on-time in seconds expires.
// RQ14: a momentary output returning idle after a group command reports.
// RQ15: leaving the condition early restarts the debounce timer from zero.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`include "rar_cfg.svh"
module rar_top
#(
  parameter int NIN      = `RAR_NUM_IN,
  parameter int NOUT     = `RAR_NUM_OUT,
  parameter int NSLOT    = `RAR_NUM_SLOTS,
  parameter int TICK_CYC = `RAR_TICK_CYC
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // digital input pins
  input  wire logic [NIN-1:0]    din_pin,
  // received frame
  input  wire logic              rx_valid,
  input  wire rar_pkg::rar_addr_t rx_addr,
  // forwarded frame
  output logic                   fwd_valid,
  output rar_pkg::rar_addr_t     fwd_addr,
  // unsolicited alarm
  output rar_pkg::rar_alarm_t    alarm,
  // output pins, enable low while driving
  output logic [NOUT-1:0]        dout_oe_b,
  // interrupt
  output logic                   irq
);
  // ***************************************************
  // synchronisers and tick
  // ***************************************************
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;
  logic [31:0]    tick_cnt_r;
  logic [3:0]     sec_cnt_r;
  logic           tick_r;
  logic           sec_tick_r;
  wire            tick_wrap = tick_cnt_r == 32'(TICK_CYC - 1);
  wire            sec_wrap  = sec_cnt_r == 4'(`RAR_SEC_TICKS - 1);
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
    end
    else
    begin
      sync1_r <= din_pin;
      sync2_r <= sync1_r;
    end
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt_r <= 32'h0000_0000;
      sec_cnt_r  <= 4'h0;
      tick_r     <= 1'b0;
      sec_tick_r <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick_wrap ? 32'h0000_0000 : tick_cnt_r + 32'h1;
      tick_r     <= tick_wrap;
      sec_tick_r <= tick_wrap && sec_wrap;
      if (tick_wrap)
        sec_cnt_r <= sec_wrap ? 4'h0 : sec_cnt_r + 4'h1;
    end
  end
  // ***************************************************
  // register decode
  // ***************************************************
  wire wr_ctrl    = reg_wr && reg_addr == `RAR_A_CTRL;
  wire wr_stat    = reg_wr && reg_addr == `RAR_A_STAT;
  wire wr_mask    = reg_wr && reg_addr == `RAR_A_MASK;
  wire wr_inen    = reg_wr && reg_addr == `RAR_A_INEN;
  wire wr_inmode  = reg_wr && reg_addr == `RAR_A_INMODE;
  wire wr_indeb   = reg_wr && reg_addr == `RAR_A_INDEB;
  wire wr_outmom  = reg_wr && reg_addr == `RAR_A_OUTMOM;
  wire wr_outont  = reg_wr && reg_addr == `RAR_A_OUTONT;
  wire wr_outcmd  = reg_wr && reg_addr == `RAR_A_OUTCMD;
  wire wr_slotsel = reg_wr && reg_addr == `RAR_A_SLOTSEL;
  wire wr_match   = reg_wr && reg_addr == `RAR_A_SLOTMATCH;
  wire wr_repl    = reg_wr && reg_addr == `RAR_A_SLOTREPL;
  wire rd_alarm   = reg_rd && reg_addr == `RAR_A_ALARM;
  // ***************************************************
  // configuration
  // ***************************************************
  logic                     exc_en_r;
  logic [2:0]               stat_r;
  logic [2:0]               mask_r;
  logic [$clog2(NIN)-1:0]   cur_in_r;
  logic [$clog2(NOUT)-1:0]  cur_out_r;
  logic [3:0]               cur_slot_r;
  logic [NIN-1:0]           in_en_r;
  rar_pkg::rar_mode_t       in_mode_r [NIN];
  logic [15:0]              in_deb_r  [NIN];
  logic [NOUT-1:0]          out_mom_r;
  logic [7:0]               out_ont_r [NOUT];
  wire  [$clog2(NIN)-1:0]   cur_in_nxt = (cur_in_r == NIN - 1) ?
                            '0 : cur_in_r + 1'b1; // [RQ11]
  wire  next_in = wr_ctrl && reg_wdata[`RAR_CTRL_NEXT];
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      exc_en_r   <= 1'b1;
      mask_r     <= 3'h0;
      cur_in_r   <= '0;
      cur_out_r  <= '0;
      cur_slot_r <= 4'h0;
      in_en_r    <= '1; // enabled after reset [RQ10]
      out_mom_r  <= '0;
      for (int i = 0; i < NIN; i++)
      begin
        in_mode_r[i] <= rar_pkg::RAR_MODE_STATUS; // [RQ10]
        in_deb_r[i]  <= `RAR_DEB_RST;             // [RQ10]
      end
      for (int i = 0; i < NOUT; i++)
        out_ont_r[i] <= `RAR_ONT_RST;
    end
    else
    begin
      if (wr_ctrl)
        exc_en_r <= reg_wdata[`RAR_CTRL_EXC];
      if (next_in)
        cur_in_r <= cur_in_nxt;
      else if (wr_inmode)
        cur_in_r <= reg_wdata[8 +: $clog2(NIN)];
      if (wr_mask)
        mask_r <= reg_wdata[2:0];
      if (wr_inen)
        in_en_r <= reg_wdata[NIN-1:0];
      if (wr_inmode)
        in_mode_r[reg_wdata[8 +: $clog2(NIN)]] <=
          rar_pkg::rar_mode_t'(reg_wdata[1:0]);
      if (wr_indeb)
        in_deb_r[cur_in_r] <= reg_wdata[15:0];
      if (wr_outmom)
        out_mom_r <= reg_wdata[NOUT-1:0];
      if (wr_outont || wr_outcmd)
        cur_out_r <= reg_wdata[16 +: $clog2(NOUT)];
      if (wr_outont)
        out_ont_r[reg_wdata[16 +: $clog2(NOUT)]] <= reg_wdata[7:0];
      if (wr_slotsel)
        cur_slot_r <= reg_wdata[3:0];
    end
  end
  // ***************************************************
  // forwarding table
  // ***************************************************
  rar_pkg::rar_addr_t match_r [NSLOT];
  rar_pkg::rar_addr_t repl_r  [NSLOT];
  logic [NSLOT-1:0]   hit;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      for (int s = 0; s < NSLOT; s++)
      begin
        match_r[s] <= '{`RAR_ADDR_RST, `RAR_ADDR_RST}; // [RQ2]
        repl_r[s]  <= '{`RAR_ADDR_RST, `RAR_ADDR_RST}; // [RQ2]
      end
    else
    begin
      if (wr_match)
        match_r[cur_slot_r] <= reg_wdata;
      if (wr_repl)
        repl_r[cur_slot_r] <= reg_wdata;
    end
  end
  genvar g;
  generate
    for (g = 0; g < NSLOT; g++)
    begin : g_hit
      assign hit[g] = rx_valid && rx_addr == match_r[g];
    end
  endgenerate
  rar_pkg::rar_addr_t sel_repl;
  always_comb
  begin
    sel_repl = '0;
    for (int s = NSLOT - 1; s >= 0; s--)
      if (hit[s])
        sel_repl = repl_r[s];
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fwd_valid <= 1'b0;
      fwd_addr  <= '0;
    end
    else
    begin
      fwd_valid <= |hit; // resend with replacement addresses [RQ3]
      if (|hit)
        fwd_addr <= sel_repl; // [RQ3]
    end
  end
  // ***************************************************
  // inputs and alarms
  // ***************************************************
  logic [NIN-1:0] fire;
  generate
    for (g = 0; g < NIN; g++)
    begin : g_din
      rar_din u_din
      (
        .clock     (clock),
        .rst_b     (rst_b),
        .tick      (tick_r),
        .mode      (in_mode_r[g]),
        .deb_ticks (in_deb_r[g]),
        .level     (sync2_r[g]),
        .fire      (fire[g])
      );
    end
  endgenerate
  // disabled inputs and global off suppress alarms [RQ1] [RQ5]
  wire [NIN-1:0] send = fire & in_en_r & {NIN{exc_en_r}}; // [RQ4]
  logic [$clog2(NIN)-1:0] send_num;
  always_comb
  begin
    send_num = '0;
    for (int i = NIN - 1; i >= 0; i--)
      if (send[i])
        send_num = i[$clog2(NIN)-1:0];
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      alarm <= '0;
    else
    begin
      alarm.valid <= |send; // [RQ4]
      // number and level hold as the last alarm for read back
      if (|send)
      begin
        alarm.input_num <= 3'(send_num);
        alarm.level     <= sync2_r[send_num]; // new level reported [RQ8]
      end
    end
  end
  // ***************************************************
  // outputs
  // ***************************************************
  logic [NOUT-1:0] drive;
  logic [NOUT-1:0] idle_rpt;
  generate
    for (g = 0; g < NOUT; g++)
    begin : g_dout
      wire sel_o = wr_outcmd && reg_wdata[16 +: $clog2(NOUT)] == g;
      rar_dout u_dout
      (
        .clock     (clock),
        .rst_b     (rst_b),
        .sec_tick  (sec_tick_r),
        .momentary (out_mom_r[g]),
        .on_secs   (out_ont_r[g]),
        .cmd_on    (sel_o && reg_wdata[`RAR_OUTCMD_ON]),
        .cmd_off   (sel_o && !reg_wdata[`RAR_OUTCMD_ON]),
        .cmd_grp   (reg_wdata[`RAR_OUTCMD_GRP]),
        .drive     (drive[g]),
        .idle_rpt  (idle_rpt[g])
      );
    end
  endgenerate
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      dout_oe_b <= '1;
    else
      dout_oe_b <= ~drive;
  end
  // ***************************************************
  // status, interrupt and read back
  // ***************************************************
  wire [2:0] ev = {exc_en_r && |idle_rpt, |hit, |send}; // [RQ14]
  wire [2:0] stat_nxt = (stat_r & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | ev;
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      `RAR_A_CTRL:      rd_mux[0] = exc_en_r;
      `RAR_A_STAT:      rd_mux[2:0] = stat_r;
      `RAR_A_MASK:      rd_mux[2:0] = mask_r;
      `RAR_A_INLVL:     rd_mux[NIN-1:0] = sync2_r; // poll view [RQ5]
      `RAR_A_INCUR:     rd_mux[$clog2(NIN)-1:0] = cur_in_r;
      `RAR_A_INEN:      rd_mux[NIN-1:0] = in_en_r;
      `RAR_A_INMODE:    rd_mux[1:0] = in_mode_r[cur_in_r];
      `RAR_A_INDEB:     rd_mux[15:0] = in_deb_r[cur_in_r];
      `RAR_A_OUTMOM:    rd_mux[NOUT-1:0] = out_mom_r;
      `RAR_A_OUTONT:    rd_mux[7:0] = out_ont_r[cur_out_r];
      `RAR_A_OUTST:     rd_mux[NOUT-1:0] = drive;
      `RAR_A_SLOTSEL:   rd_mux[3:0] = cur_slot_r;
      `RAR_A_SLOTMATCH: rd_mux = match_r[cur_slot_r];
      `RAR_A_SLOTREPL:  rd_mux = repl_r[cur_slot_r];
      `RAR_A_ALARM:     rd_mux[4:0] = {alarm.input_num, alarm.level, 1'b0};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_r    <= 3'h0;
      irq       <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      stat_r    <= stat_nxt;
      irq       <= |(stat_nxt & mask_r);
      reg_rdata <= (reg_rd && !rd_alarm) || rd_alarm ? rd_mux : 32'h0;
    end
  end
endmodule // rar_top

// file: tb/rar_top_properties.sv
// port checker of the alarm and relay block
// ****************
// checker
// ****************
module rar_top_chk
#(
  parameter int NOUT = 8
)
(
  // clock and reset
  input wire logic                clock,
  input wire logic                rst_b,
  // register port
  input wire logic [7:0]          reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  // frames and events
  input wire logic                rx_valid,
  input wire logic                fwd_valid,
  input wire rar_pkg::rar_alarm_t alarm,
  input wire logic [NOUT-1:0]     dout_oe_b,
  input wire logic                irq
);
  logic [NOUT-1:0] mom_r;
  logic [31:0]     mask_r;
  logic            exc_r;
  logic [2:0]      idx_r;
  logic [1:0]      off_cnt_r;
  wire logic       cmd_wr;
  wire logic [1:0] off_cnt_nxt;
  assign cmd_wr = reg_wr && reg_addr == 8'h28;
  assign off_cnt_nxt = (cmd_wr && !reg_wdata[8]) ? 2'h3 :
                       (off_cnt_r != 2'h0) ? off_cnt_r - 2'h1 : 2'h0;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mom_r     <= '0;
      mask_r    <= 32'h0;
      exc_r     <= 1'b1;
      idx_r     <= 3'h0;
      off_cnt_r <= 2'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h20) mom_r <= reg_wdata[NOUT-1:0];
      if (reg_wr && reg_addr == 8'h08) mask_r <= reg_wdata;
      if (reg_wr && reg_addr == 8'h00) exc_r <= reg_wdata[0];
      if (cmd_wr) idx_r <= reg_wdata[18:16];
      off_cnt_r <= off_cnt_nxt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_latched_on;
    cmd_wr && reg_wdata[8] && !mom_r[reg_wdata[18:16]];
  endsequence
  sequence s_drive_on;
    !dout_oe_b[idx_r];
  endsequence
  chk_latched_on: assert property (s_latched_on |-> ##[1:3] s_drive_on)
    else $error("latched output not driven after on command");
  chk_latched_hold: assert property
    ((dout_oe_b & ~$past(dout_oe_b) & ~mom_r) != {NOUT{1'b0}}
     |-> off_cnt_r != 2'h0)
    else $error("latched output dropped without off command");
  chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read answer cycle");
  chk_fwd_cause: assert property (fwd_valid |-> $past(rx_valid))
    else $error("forwarded frame without received frame");
  chk_alarm_gap: assert property
    (alarm.valid && $past(alarm.valid)
     |-> alarm.input_num != $past(alarm.input_num))
    else $error("one input alarmed in two adjacent cycles");
  chk_poll_only: assert property
    (!exc_r && !$past(exc_r) && !$past(exc_r, 2) |-> !alarm.valid)
    else $error("alarm sent while reporting off");
  chk_reset_outputs: assert property (disable iff (1'b0)
    !rst_b |-> dout_oe_b == {NOUT{1'b1}} && !irq && !fwd_valid)
    else $error("outputs not idle in reset");
  chk_irq_mask: assert property
    (mask_r == 32'h0 && $past(mask_r) == 32'h0 |-> !irq)
    else $error("interrupt with all sources masked");
endmodule // rar_top_chk
bind rar_top rar_top_chk #(.NOUT(NOUT)) u_rar_top_chk (.clock(clock),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_valid(rx_valid), .fwd_valid(fwd_valid), .alarm(alarm),
  .dout_oe_b(dout_oe_b), .irq(irq));

// file: tb/rar_ctl.sv
// far side controller model: sends frames, collects alarms
// ****************
// controller model
// ****************
module rar_ctl
(
  // clock
  input wire logic                clock,
  // frame to the unit
  output logic                    rx_valid,
  output rar_pkg::rar_addr_t      rx_addr,
  // traffic from the unit
  input wire logic                fwd_valid,
  input wire rar_pkg::rar_addr_t  fwd_addr,
  input wire rar_pkg::rar_alarm_t alarm
);
  timeunit 1ns;
  timeprecision 1ps;
  int         alarm_cnt = 0;
  logic       alarm_lvl;
  logic [2:0] alarm_num;
  initial
  begin
    rx_valid = 1'b0;
    rx_addr  = 32'h0;
  end
  always @(posedge clock)
  begin
    if (alarm.valid === 1'b1)
    begin
      alarm_cnt++;
      alarm_lvl = alarm.level;
      alarm_num = alarm.input_num;
    end
  end
  // idle header lines show the inverse of the last frame
  task send(input rar_pkg::rar_addr_t a, output logic got,
            output rar_pkg::rar_addr_t fa);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_addr  <= a;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_addr  <= ~a;
    #1;
    got = fwd_valid;
    fa  = fwd_addr;
  endtask
endmodule // rar_ctl

// file: tb/tb.sv
// testbench of the alarm and relay block
// ****************
// testbench
// ****************
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]          reg_addr, din_pin, dout_oe_b;
  logic [31:0]         reg_wdata, reg_rdata, seed, q;
  logic                clock, rst_b, reg_wr, reg_rd, rx_valid;
  logic                fwd_valid, irq, got;
  rar_pkg::rar_addr_t  rx_addr, fwd_addr, fa, tm [16], tr [16];
  rar_pkg::rar_alarm_t alarm;
  int                  bad_count = 0;
  int                  comparisons = 0;
  rar_top #(.TICK_CYC(10)) u_rar_top (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .din_pin(din_pin),
    .rx_valid(rx_valid), .rx_addr(rx_addr), .fwd_valid(fwd_valid),
    .fwd_addr(fwd_addr), .alarm(alarm), .dout_oe_b(dout_oe_b), .irq(irq));
  rar_ctl u_rar_ctl (.clock(clock), .rx_valid(rx_valid),
    .rx_addr(rx_addr), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
    .alarm(alarm));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0);
  endfunction
  function automatic logic exp_alarm(input int m, input logic o, n);
    return m == 0 ? o != n : m == 1 ? o && !n : !o && n;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // one pin edge, alarm count compared with the mode's expectation
  task pin(input int k, input logic v, input int m, input logic en);
    int   n;
    logic o;
    n = u_rar_ctl.alarm_cnt;
    o = din_pin[k];
    @(posedge clock);
    din_pin[k] <= v;
    cyc(12);
    chk(u_rar_ctl.alarm_cnt - n, en && exp_alarm(m, o, v));
  endtask
  // low pulse of len cycles on pin k
  task low(input int k, input int len, input logic e);
    int n;
    n = u_rar_ctl.alarm_cnt;
    @(posedge clock);
    din_pin[k] <= 1'b0;
    cyc(len);
    din_pin[k] <= 1'b1;
    cyc(12);
    chk(u_rar_ctl.alarm_cnt - n, e);
  endtask
  task print_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    print_verdict;
  end
  initial
  begin
    rst_b = 1'b1; reg_addr = 8'h0; reg_wdata = 32'h0; reg_wr = 1'b0;
    reg_rd = 1'b0; din_pin = 8'hff; seed = 32'h07e4;
    #1 rst_b = 1'b0;
    cyc(8);
    rst_b <= 1'b1;
    rd(8'h00, q); chk(q & 32'h1, 32'h1);
    rd(8'h14, q); chk(q, 32'hff);
    rd(8'h18, q); chk(q, 32'h0);
    rd(8'h1c, q); chk(q, 32'h0);
    rd(8'h34, q); chk(q, 32'h0);
    rd(8'hfc, q); chk(q, 32'h0);
    u_rar_ctl.send(32'h0, got, fa); chk(got, 1'b1); chk(fa, 32'h0);
    tm[0] = {16'd0, 16'd10};
    tr[0] = {16'd5, 16'd150};
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      if (i > 0) tm[i] = seed;
      seed = lfsr(seed);
      if (i > 0) tr[i] = seed;
      wr(8'h30, i);
      wr(8'h34, tm[i]);
      wr(8'h38, tr[i]);
    end
    rd(8'h34, q); chk(q, tm[15]);
    for (int i = 0; i < 16; i++)
    begin
      u_rar_ctl.send(tm[i], got, fa);
      chk(got, 1'b1); chk(fa, tr[i]);
    end
    u_rar_ctl.send({16'd150, 16'd6}, got, fa); chk(got, 1'b0);
    repeat (7) wr(8'h00, 32'h3);
    rd(8'h10, q); chk(q, 32'h7);
    wr(8'h00, 32'h3);
    rd(8'h10, q); chk(q, 32'h0);
    for (int m = 0; m < 3; m++)
    begin
      wr(8'h18, (m << 8) | m);
      pin(m, 1'b0, m, 1'b1);
      if (m == 0) chk(u_rar_ctl.alarm_lvl, 1'b0);
      pin(m, 1'b1, m, 1'b1);
      if (m == 0) chk(u_rar_ctl.alarm_lvl, 1'b1);
      chk(u_rar_ctl.alarm_num, m);
    end
    wr(8'h14, 32'hdf);
    pin(5, 1'b0, 0, 1'b0);
    rd(8'h0c, q); chk(q[5], 1'b0);
    pin(5, 1'b1, 0, 1'b0);
    wr(8'h14, 32'hff);
    wr(8'h00, 32'h0);
    pin(0, 1'b0, 0, 1'b0);
    pin(0, 1'b1, 0, 1'b0);
    wr(8'h00, 32'h1);
    wr(8'h18, 32'h401);
    wr(8'h1c, 32'h3);
    low(4, 15, 1'b0);
    low(4, 15, 1'b0);
    low(4, 60, 1'b1);
    wr(8'h20, 32'h2);
    wr(8'h24, 32'h0001_0002);
    wr(8'h28, 32'h100);
    cyc(3); chk(dout_oe_b[0], 1'b0);
    cyc(150); rd(8'h2c, q); chk(q[0], 1'b1);
    wr(8'h28, 32'h0);
    cyc(3); chk(dout_oe_b[0], 1'b1);
    wr(8'h08, 32'h4);
    wr(8'h28, 32'h0001_0300);
    cyc(3); chk(dout_oe_b[1], 1'b0);
    cyc(50); chk(dout_oe_b[1], 1'b0);
    cyc(170); chk(dout_oe_b[1], 1'b1);
    rd(8'h04, q); chk(q[2], 1'b1); chk(irq, 1'b1);
    chk(q[1:0], 2'h3);
    wr(8'h04, 32'h4);
    cyc(2); chk(irq, 1'b0);
    print_verdict;
  end
endmodule // tb
